// *** inc/vad_pkg.sv ***
package vad_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int VAD_CHANNELS   = 23;
    localparam int VAD_ENERGY_W   = 24;
    localparam int VAD_METRIC_W   = 12;
    localparam int VAD_DEV_W      = 12;
    localparam int VAD_SNR_W      = 5;
    localparam int VAD_TABLE_SIZE = 20;
    localparam int VAD_THR_W      = 8;
    localparam int VAD_CNT_W      = 10;
    localparam int VAD_HYST_W     = 4;
    localparam int VAD_FRAME_W    = 4;

    // ------------------------------------------------------------
    // decision constants
    // ------------------------------------------------------------
    localparam logic [VAD_DEV_W-1:0]   VAD_SPECTRAL_DEVIATION_LIMIT = 12'h046;
    localparam logic [VAD_CNT_W-1:0]   VAD_REFRESH_COUNTER_LIMIT    = 10'h1F4;
    localparam logic [VAD_CNT_W-1:0]   VAD_REFRESH_COUNTER_MAX      = 10'h3FF;
    localparam logic [VAD_HYST_W-1:0]  VAD_STALL_FRAMES_LIMIT       = 4'h9;
    localparam logic [VAD_HYST_W-1:0]  VAD_HYST_MAX                 = 4'hF;
    localparam logic [VAD_FRAME_W-1:0] VAD_INIT_FRAMES              = 4'hA;
    localparam logic [VAD_SNR_W-1:0]   VAD_SNR_INDEX_MAX            = 5'h13;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [VAD_THR_W-1:0]    VAD_VOICE_THR_RESET   = 8'h38;
    localparam logic [VAD_THR_W-1:0]    VAD_HANG_THR_RESET    = 8'h1C;
    localparam logic [VAD_THR_W-1:0]    VAD_BURST_THR_RESET   = 8'h06;
    localparam logic [VAD_ENERGY_W-1:0] VAD_NOISE_INIT        = 24'h001388;

    // ------------------------------------------------------------
    // snr-indexed tables
    // ------------------------------------------------------------
    localparam logic [VAD_THR_W-1:0] VAD_REFRESH_TABLE [VAD_TABLE_SIZE] = '{
        8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h25, 8'h25, 8'h25,
        8'h25, 8'h25, 8'h25, 8'h25, 8'h25, 8'h26, 8'h26, 8'h26, 8'h26, 8'h26};
    localparam logic [VAD_THR_W-1:0] VAD_VOICE_TABLE [VAD_TABLE_SIZE] = '{
        8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h30, 8'h32,
        8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h39, 8'h3A, 8'h3A, 8'h3A, 8'h3A};
    localparam logic [VAD_THR_W-1:0] VAD_HANG_TABLE [VAD_TABLE_SIZE] = '{
        8'h36, 8'h34, 8'h32, 8'h30, 8'h2E, 8'h2C, 8'h2A, 8'h28, 8'h26, 8'h24,
        8'h22, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h16, 8'h14, 8'h12, 8'h10};
    localparam logic [VAD_THR_W-1:0] VAD_BURST_TABLE [VAD_TABLE_SIZE] = '{
        8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h05, 8'h05,
        8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06};

endpackage

// *** hw/vad_noise_smoother.sv ***
`timescale 1ns/1ps
`default_nettype none

module vad_noise_smoother #(
    parameter int CHANNELS = vad_pkg::VAD_CHANNELS,
    parameter int ENERGY_W = vad_pkg::VAD_ENERGY_W
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         ce,
    input  wire logic                         refresh,
    input  wire logic [CHANNELS*ENERGY_W-1:0] channel_energy,
    output var  logic [CHANNELS*ENERGY_W-1:0] noise_estimate
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    initial begin
        if (CHANNELS < 1 || ENERGY_W < 4 || ENERGY_W > 28) begin
            $error("vad_noise_smoother: unsupported channel count or width");
        end
    end

    // ------------------------------------------------------------
    // per-channel smoothing
    // ------------------------------------------------------------
    // exact 0.9/0.1 weighting via one constant divide; the sum cannot
    // overflow since 9*n + e < 10 * 2^ENERGY_W
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
            logic [ENERGY_W-1:0] est_ff;
            logic [ENERGY_W+3:0] weighted;
            logic [ENERGY_W-1:0] nxt_est;

            assign weighted = (ENERGY_W+4)'(est_ff) * (ENERGY_W+4)'(9)
                            + (ENERGY_W+4)'(channel_energy[ch*ENERGY_W +: ENERGY_W]);
            assign nxt_est  = ENERGY_W'(weighted / (ENERGY_W+4)'(10));

            always_ff @(posedge clk) begin
                if (reset) begin
                    est_ff <= ENERGY_W'(vad_pkg::VAD_NOISE_INIT);
                end else if (ce && refresh) begin
                    est_ff <= nxt_est;
                end
            end

            // held between refreshes and fed back upstream
            assign noise_estimate[ch*ENERGY_W +: ENERGY_W] = est_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// *** hw/vad_decision.sv ***
// Overview of operation
// - noise refresh threshold comes from a 20-entry table addressed by snr index.
// - refresh and forced refresh flags are cleared before each frame's evaluation.
// - equal refresh count to captured value increments stall count, else clear and capture.
// - stall count above 9 frames resets the refresh counter to zero.
// - spectral deviation limit 70 and refresh counter limit 500 drive refresh decisions.
// - on refresh each of 23 noise estimates becomes 0.9 old plus 0.1 energy.
// - noise estimates hold until next refresh and feed back upstream.
// - during initial noise-only frames voice and hangover outputs are forced false.
// - ten frames after reset are treated as noise-only.
// - metric above voice threshold sets local decision, counts burst, may load hangover.
// - voice active when local decision true or hangover count above zero.
// - no local decision and hangover above zero asserts hangover and decrements count.
// - reset gives thresholds 56, 28, 6 and clears hangover and burst counters.
// - each frame ends by loading next thresholds from three snr-indexed tables.
// - voice table rises 32 to 58, hangover falls 54 to 16, burst 2 to 6.
`timescale 1ns/1ps
`default_nettype none

module vad_decision #(
    parameter int CHANNELS = vad_pkg::VAD_CHANNELS,
    parameter int ENERGY_W = vad_pkg::VAD_ENERGY_W,
    parameter int METRIC_W = vad_pkg::VAD_METRIC_W
) (
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    input  wire logic                                  ce,
    input  wire logic                                  frame_strobe,
    input  wire logic [METRIC_W-1:0]                   voice_metric,
    input  wire logic [vad_pkg::VAD_DEV_W-1:0]         spectral_deviation,
    input  wire logic                                  peak_ratio_low,
    input  wire logic [vad_pkg::VAD_SNR_W-1:0]         quantized_snr_index,
    input  wire logic [CHANNELS*ENERGY_W-1:0]          channel_energy,
    output var  logic                                  vad_active,
    output var  logic                                  hangover_active,
    output var  logic                                  noise_refresh,
    output var  logic                                  forced_refresh,
    output var  logic                                  decision_valid,
    output var  logic                                  init_done,
    output var  logic [vad_pkg::VAD_THR_W-1:0]         voice_threshold,
    output var  logic [vad_pkg::VAD_THR_W-1:0]         hangover_threshold,
    output var  logic [vad_pkg::VAD_THR_W-1:0]         burst_threshold,
    output var  logic [CHANNELS*ENERGY_W-1:0]          noise_estimate
);

    localparam int THR_W = vad_pkg::VAD_THR_W;
    localparam int CNT_W = vad_pkg::VAD_CNT_W;
    localparam int HYS_W = vad_pkg::VAD_HYST_W;
    localparam int FRM_W = vad_pkg::VAD_FRAME_W;
    localparam int SNR_W = vad_pkg::VAD_SNR_W;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // metric must be at least as wide as the thresholds it is compared to
    initial begin
        if (METRIC_W < THR_W || METRIC_W > 16) begin
            $error("vad_decision: unsupported voice metric width");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [THR_W-1:0] voice_thr_ff;
    logic [THR_W-1:0] hang_thr_ff;
    logic [THR_W-1:0] burst_thr_ff;
    logic [THR_W-1:0] hang_cnt_ff;
    logic [THR_W-1:0] burst_cnt_ff;
    logic [CNT_W-1:0] refresh_cnt_ff;
    logic [CNT_W-1:0] last_refresh_cnt_ff;
    logic [HYS_W-1:0] stall_cnt_ff;
    logic [FRM_W-1:0] frame_cnt_ff;
    logic             vad_active_ff;
    logic             hangover_ff;
    logic             refresh_ff;
    logic             forced_ff;
    logic             valid_ff;

    // ------------------------------------------------------------
    // frame step and initial noise-only period
    // ------------------------------------------------------------
    logic             step;
    logic             in_init;
    logic [FRM_W-1:0] nxt_frame_cnt;

    // one evaluation per strobe; ce low freezes everything
    assign step          = ce && frame_strobe;
    assign in_init       = frame_cnt_ff < vad_pkg::VAD_INIT_FRAMES;
    assign nxt_frame_cnt = in_init ? frame_cnt_ff + FRM_W'(1) : frame_cnt_ff;

    // ------------------------------------------------------------
    // snr index and table lookups
    // ------------------------------------------------------------
    // an index past the table end is clamped rather than wrapped
    logic [SNR_W-1:0] snr_idx;
    logic [THR_W-1:0] refresh_thr;
    logic [THR_W-1:0] nxt_voice_thr;
    logic [THR_W-1:0] nxt_hang_thr;
    logic [THR_W-1:0] nxt_burst_thr;

    assign snr_idx       = (quantized_snr_index > vad_pkg::VAD_SNR_INDEX_MAX) ?
                           vad_pkg::VAD_SNR_INDEX_MAX : quantized_snr_index;
    assign refresh_thr   = vad_pkg::VAD_REFRESH_TABLE[snr_idx];
    assign nxt_voice_thr = vad_pkg::VAD_VOICE_TABLE[snr_idx];
    assign nxt_hang_thr  = vad_pkg::VAD_HANG_TABLE[snr_idx];
    assign nxt_burst_thr = vad_pkg::VAD_BURST_TABLE[snr_idx];

    // ------------------------------------------------------------
    // noise refresh decision
    // ------------------------------------------------------------
    logic             below_refresh;
    logic             creeping;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] cnt_mid;
    logic             forced_now;
    logic             refresh_now;

    // flags start false each frame and are only set by the terms below
    assign below_refresh = voice_metric <= METRIC_W'(refresh_thr);
    assign creeping      = !below_refresh && peak_ratio_low &&
                           (spectral_deviation < vad_pkg::VAD_SPECTRAL_DEVIATION_LIMIT);
    assign cnt_inc       = (refresh_cnt_ff == vad_pkg::VAD_REFRESH_COUNTER_MAX) ?
                           refresh_cnt_ff : refresh_cnt_ff + CNT_W'(1);
    assign cnt_mid       = below_refresh ? '0 : (creeping ? cnt_inc : refresh_cnt_ff);
    assign forced_now    = !in_init && !below_refresh &&
                           (cnt_mid >= vad_pkg::VAD_REFRESH_COUNTER_LIMIT);
    assign refresh_now   = !in_init && (below_refresh || forced_now);

    // ------------------------------------------------------------
    // stall hysteresis on the refresh counter
    // ------------------------------------------------------------
    // stops a slowly creeping count from forcing a false refresh
    logic             cnt_same;
    logic [HYS_W-1:0] nxt_stall_cnt;
    logic [CNT_W-1:0] nxt_last_cnt;
    logic [CNT_W-1:0] nxt_refresh_cnt;

    assign cnt_same        = cnt_mid == last_refresh_cnt_ff;
    assign nxt_stall_cnt   = !cnt_same ? '0 :
                             ((stall_cnt_ff == vad_pkg::VAD_HYST_MAX) ?
                              stall_cnt_ff : stall_cnt_ff + HYS_W'(1));
    assign nxt_last_cnt    = cnt_same ? last_refresh_cnt_ff : cnt_mid;
    assign nxt_refresh_cnt = (nxt_stall_cnt > vad_pkg::VAD_STALL_FRAMES_LIMIT) ?
                             '0 : cnt_mid;

    // ------------------------------------------------------------
    // voice activity and hangover
    // ------------------------------------------------------------
    logic             vad_local;
    logic [THR_W-1:0] burst_inc;
    logic [THR_W-1:0] hang_mid;
    logic             vad_now;
    logic             hang_now;
    logic [THR_W-1:0] nxt_hang_cnt;
    logic [THR_W-1:0] nxt_burst_cnt;

    assign vad_local     = voice_metric > METRIC_W'(voice_thr_ff);
    assign burst_inc     = (burst_cnt_ff == '1) ? burst_cnt_ff : burst_cnt_ff + THR_W'(1);
    assign hang_mid      = (vad_local && burst_inc >= burst_thr_ff) ?
                           hang_thr_ff : hang_cnt_ff;
    assign vad_now       = vad_local || (hang_mid != '0);
    assign hang_now      = !vad_local && (hang_mid != '0);
    assign nxt_hang_cnt  = hang_now ? hang_mid - THR_W'(1) : hang_mid;
    assign nxt_burst_cnt = vad_local ? burst_inc : '0;

    // ------------------------------------------------------------
    // threshold registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            voice_thr_ff <= vad_pkg::VAD_VOICE_THR_RESET;
            hang_thr_ff  <= vad_pkg::VAD_HANG_THR_RESET;
            burst_thr_ff <= vad_pkg::VAD_BURST_THR_RESET;
        end else if (step) begin
            voice_thr_ff <= nxt_voice_thr;
            hang_thr_ff  <= nxt_hang_thr;
            burst_thr_ff <= nxt_burst_thr;
        end
    end

    // ------------------------------------------------------------
    // frame counter and refresh counters
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            frame_cnt_ff        <= '0;
            refresh_cnt_ff      <= '0;
            last_refresh_cnt_ff <= '0;
            stall_cnt_ff        <= '0;
        end else if (step) begin
            frame_cnt_ff <= nxt_frame_cnt;
            if (!in_init) begin
                refresh_cnt_ff      <= nxt_refresh_cnt;
                last_refresh_cnt_ff <= nxt_last_cnt;
                stall_cnt_ff        <= nxt_stall_cnt;
            end
        end
    end

    // ------------------------------------------------------------
    // voice counters
    // ------------------------------------------------------------
    // counters stay at their reset values while the noise-only frames run
    always_ff @(posedge clk) begin
        if (reset) begin
            hang_cnt_ff  <= '0;
            burst_cnt_ff <= '0;
        end else if (step && !in_init) begin
            hang_cnt_ff  <= nxt_hang_cnt;
            burst_cnt_ff <= nxt_burst_cnt;
        end
    end

    // ------------------------------------------------------------
    // per-frame decision outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            vad_active_ff <= 1'b0;
            hangover_ff   <= 1'b0;
            refresh_ff    <= 1'b0;
            forced_ff     <= 1'b0;
        end else if (step) begin
            vad_active_ff <= !in_init && vad_now;
            hangover_ff   <= !in_init && hang_now;
            refresh_ff    <= refresh_now;
            forced_ff     <= forced_now;
        end
    end

    // valid marks the cycle after each evaluation; it holds while ce is low
    always_ff @(posedge clk) begin
        if (reset) begin
            valid_ff <= 1'b0;
        end else if (ce) begin
            valid_ff <= frame_strobe;
        end
    end

    // ------------------------------------------------------------
    // noise estimate storage
    // ------------------------------------------------------------
    // energies are sampled on the strobe, the same edge the decision is made
    vad_noise_smoother #(
        .CHANNELS (CHANNELS),
        .ENERGY_W (ENERGY_W)
    ) u_smoother (
        .clk            (clk),
        .reset          (reset),
        .ce             (step),
        .refresh        (refresh_now),
        .channel_energy (channel_energy),
        .noise_estimate (noise_estimate)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign vad_active         = vad_active_ff;
    assign hangover_active    = hangover_ff;
    assign noise_refresh      = refresh_ff;
    assign forced_refresh     = forced_ff;
    assign decision_valid     = valid_ff;
    assign voice_threshold    = voice_thr_ff;
    assign hangover_threshold = hang_thr_ff;
    assign burst_threshold    = burst_thr_ff;

    // init_done is a flop of its own so it stays a direct register output
    logic init_done_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            init_done_ff <= 1'b0;
        end else if (step) begin
            init_done_ff <= !(nxt_frame_cnt < vad_pkg::VAD_INIT_FRAMES);
        end
    end

    assign init_done = init_done_ff;

endmodule

`default_nettype wire

// *** tb/vad_decision_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module vad_decision_sva #(
    parameter int CHANNELS = vad_pkg::VAD_CHANNELS,
    parameter int ENERGY_W = vad_pkg::VAD_ENERGY_W,
    parameter int METRIC_W = vad_pkg::VAD_METRIC_W
) (
    input wire logic                         clk,
    input wire logic                         reset,
    input wire logic                         ce,
    input wire logic                         frame_strobe,
    input wire logic [METRIC_W-1:0]          voice_metric,
    input wire logic [4:0]                   quantized_snr_index,
    input wire logic                         vad_active,
    input wire logic                         hangover_active,
    input wire logic                         noise_refresh,
    input wire logic                         forced_refresh,
    input wire logic                         decision_valid,
    input wire logic                         init_done,
    input wire logic [7:0]                   voice_threshold,
    input wire logic [7:0]                   hangover_threshold,
    input wire logic [7:0]                   burst_threshold,
    input wire logic [CHANNELS*ENERGY_W-1:0] noise_estimate
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [4:0] snr_c;
    logic [3:0] frames_ff;
    logic [3:0] nxt_frames;
    assign snr_c = (quantized_snr_index > 5'h13) ? 5'h13 : quantized_snr_index;
    assign nxt_frames = (ce && frame_strobe && frames_ff != 4'hA) ? frames_ff + 4'h1 : frames_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            frames_ff <= 4'h0;
        end else begin
            frames_ff <= nxt_frames;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        ce && frame_strobe;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_valid_after_take: assert property (s_take |=> decision_valid)
        else $error("no valid");
    a_valid_one_cycle: assert property (ce && !frame_strobe |=> !decision_valid)
        else $error("stray valid");
    a_outputs_hold: assert property (!(ce && frame_strobe) |=> $stable(vad_active)
        && $stable(hangover_active) && $stable(voice_threshold) && $stable(burst_threshold))
        else $error("outputs moved");
    a_init_quiet: assert property (!init_done |-> !vad_active && !hangover_active
        && !noise_refresh && !forced_refresh) else $error("init activity");
    a_init_after_ten: assert property (init_done == (frames_ff == 4'hA))
        else $error("init done");
    a_refresh_low_metric: assert property (s_take and init_done
        && voice_metric <= {4'h0, vad_pkg::VAD_REFRESH_TABLE[snr_c]} |=> noise_refresh
        && !forced_refresh) else $error("no refresh");
    a_vad_high_metric: assert property (s_take and init_done
        && voice_metric > {4'h0, voice_threshold} |=> vad_active && !hangover_active)
        else $error("no voice");
    a_hang_means_vad: assert property (hangover_active |-> vad_active)
        else $error("lone hangover");
    a_forced_refresh: assert property (forced_refresh |-> noise_refresh)
        else $error("lone forced");
    a_noise_holds: assert property (decision_valid && !noise_refresh |-> $stable(noise_estimate))
        else $error("noise moved");
    a_voice_table: assert property (s_take |=>
        voice_threshold == vad_pkg::VAD_VOICE_TABLE[$past(snr_c)]) else $error("voice threshold");
    a_hang_table: assert property (s_take |=>
        hangover_threshold == vad_pkg::VAD_HANG_TABLE[$past(snr_c)]
        && burst_threshold == vad_pkg::VAD_BURST_TABLE[$past(snr_c)]) else $error("tables");
endmodule

bind vad_decision vad_decision_sva #(.CHANNELS(CHANNELS), .ENERGY_W(ENERGY_W),
    .METRIC_W(METRIC_W)) i_vad_decision_sva (.clk(clk), .reset(reset), .ce(ce),
    .frame_strobe(frame_strobe), .voice_metric(voice_metric),
    .quantized_snr_index(quantized_snr_index),
    .vad_active(vad_active), .hangover_active(hangover_active), .noise_refresh(noise_refresh),
    .forced_refresh(forced_refresh), .decision_valid(decision_valid), .init_done(init_done),
    .voice_threshold(voice_threshold), .hangover_threshold(hangover_threshold),
    .burst_threshold(burst_threshold), .noise_estimate(noise_estimate));

`default_nettype wire

// *** tb/vad_upstream_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module vad_upstream_model (
    input  wire logic         clk,
    input  wire logic         go,
    input  wire logic [53:0]  frame_in,
    output var  logic         frame_strobe,
    output var  logic [11:0]  voice_metric,
    output var  logic [11:0]  spectral_deviation,
    output var  logic         peak_ratio_low,
    output var  logic [4:0]   quantized_snr_index,
    output var  logic [551:0] channel_energy
);
    // fields toggle between frames, so a late sample reads junk
    always_ff @(posedge clk) begin
        frame_strobe <= go;
        if (go) begin
            {voice_metric, spectral_deviation, peak_ratio_low, quantized_snr_index} <= frame_in[53:24];
            channel_energy <= {23{frame_in[23:0]}};
        end else begin
            {voice_metric, spectral_deviation, peak_ratio_low, quantized_snr_index} <=
                ~{voice_metric, spectral_deviation, peak_ratio_low, quantized_snr_index};
            channel_energy <= ~channel_energy;
        end
    end
endmodule

`default_nettype wire

// *** tb/vad_decision_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module vad_decision_tb_top;
    logic         clk, reset, ce, go, frame_strobe, peak_ratio_low;
    logic [53:0]  frame_in;
    logic [11:0]  voice_metric, spectral_deviation;
    logic [4:0]   quantized_snr_index;
    logic [551:0] channel_energy, noise_estimate;
    logic         vad_active, hangover_active, noise_refresh, forced_refresh;
    logic         decision_valid, init_done, ev, eh, er, ef;
    logic [7:0]   voice_threshold, hangover_threshold, burst_threshold;
    int           errors, n_compared, k, burst, hang, cnt, last, stall, i;
    int           vthr = 56, hthr = 28, bthr = 6, noise = 5000;

    vad_upstream_model i_vad_upstream_model (.clk(clk), .go(go), .frame_in(frame_in),
        .frame_strobe(frame_strobe), .voice_metric(voice_metric),
        .spectral_deviation(spectral_deviation), .peak_ratio_low(peak_ratio_low),
        .quantized_snr_index(quantized_snr_index), .channel_energy(channel_energy));
    vad_decision i_vad_decision (.clk(clk), .reset(reset), .ce(ce), .frame_strobe(frame_strobe),
        .voice_metric(voice_metric), .spectral_deviation(spectral_deviation),
        .peak_ratio_low(peak_ratio_low), .quantized_snr_index(quantized_snr_index),
        .channel_energy(channel_energy), .vad_active(vad_active), .hangover_active(hangover_active),
        .noise_refresh(noise_refresh), .forced_refresh(forced_refresh),
        .decision_valid(decision_valid), .init_done(init_done), .voice_threshold(voice_threshold),
        .hangover_threshold(hangover_threshold), .burst_threshold(burst_threshold),
        .noise_estimate(noise_estimate));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_all(input logic en);
        chk(decision_valid, en);
        chk(vad_active, ev);
        chk(hangover_active, eh);
        chk(noise_refresh, er);
        chk(forced_refresh, ef);
        chk(voice_threshold, vthr);
        chk(hangover_threshold, hthr);
        chk(burst_threshold, bthr);
        chk(noise_estimate[23:0], noise);
        chk(noise_estimate[551:528], noise);
        chk(init_done, k >= 10);
    endtask

    // one frame through the upstream model, then the reference state steps along
    task automatic frame(input logic en, input logic [11:0] m, input logic [11:0] d,
                         input logic l, input logic [4:0] s, input int e);
        int   t;
        int   sc;
        logic loc;
        @(posedge clk);
        ce <= en;
        go <= 1'b1;
        frame_in <= {m, d, l, s, e[23:0]};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        sc = (s > 19) ? 19 : s;
        t = vad_pkg::VAD_REFRESH_TABLE[sc];
        if (en) begin
            {ev, eh, er, ef} = 4'h0;
            if (k >= 10) begin
                cnt = (m <= t) ? 0 : (d < 70 && l && cnt < 1023) ? cnt + 1 : cnt;
                er = (m <= t) || cnt >= 500;
                ef = (m > t) && cnt >= 500;
                stall = (cnt == last) ? ((stall < 15) ? stall + 1 : 15) : 0;
                last = cnt;
                cnt = (stall > 9) ? 0 : cnt;
                loc = m > vthr;
                burst = loc ? burst + 1 : 0;
                hang = (loc && burst >= bthr) ? hthr : hang;
                ev = loc || hang > 0;
                eh = !loc && hang > 0;
                hang = eh ? hang - 1 : hang;
                noise = er ? (9 * noise + e) / 10 : noise;
            end
            k = k + 1;
            vthr = vad_pkg::VAD_VOICE_TABLE[sc];
            hthr = vad_pkg::VAD_HANG_TABLE[sc];
            bthr = vad_pkg::VAD_BURST_TABLE[sc];
        end
        check_all(en);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        go = 1'b0;
        frame_in = '0;
        {ev, eh, er, ef} = 4'h0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        check_all(1'b0);
        for (i = 0; i < 10; i++) frame(1, 12'hFFF, 12'h000, 1, 5'(i), 256);
        frame(1, 12'h000, 12'h046, 0, 5'h13, 65535);
        for (i = 0; i < 8; i++) frame(1, 12'hFFF, 12'h080, 0, 5'h00, 4096);
        for (i = 0; i < 60; i++) frame(1, 12'h020, 12'h080, 1, 5'h00, 4096);
        for (i = 0; i < 12; i++) frame(1, 12'h020, 12'h045, 1, 5'h00, 4096);
        for (i = 0; i < 6; i++) frame(1, 12'h020, 12'h046, 1, 5'h00, 4096);
        for (i = 0; i < 6; i++) frame(1, 12'h020, 12'h045, 0, 5'h00, 4096);
        for (i = 0; i < 502; i++) frame(1, 12'h020, 12'h045, 1, 5'h00, 9000);
        frame(0, 12'hFFF, 12'h000, 1, 5'h07, 100);
        frame(1, 12'h000, 12'h045, 1, 5'h00, 300);
        for (i = 0; i < 21; i++) frame(1, 12'h030, 12'h080, 0, (i == 20) ? 5'h1F : 5'(i), 4096);
        tally_and_finish();
    end
endmodule

`default_nettype wire
